// ---- src/smps_protect.sv ----
// The Wishbone register port and the address map were left to the implementer.
`include "smps_defs.svh"
`default_nettype none
module smps_protect #(
  parameter int BLANK_CYC  = `SMPS_BLANK_MS * 1000 * `SMPS_CLK_MHZ,
  parameter int DETECT_CYC = `SMPS_DETECT_MS * 1000 * `SMPS_CLK_MHZ,
  parameter int DET_CNT_W  = 16,
  parameter int LVL1_MIN   = 4,
  parameter int LVL2_MIN   = 16,
  parameter int LVL3_MIN   = 64
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        osc_set,
  input  wire logic        peak_limit_comparator,
  input  wire logic        burst_limit_comparator,
  input  wire logic        amp_cmp,
  input  wire logic        overload_cmp,
  input  wire logic        burst_entry_cmp,
  input  wire logic        burst_exit_cmp,
  input  wire logic        extend_high_comparator,
  input  wire logic        extend_low_comparator,
  input  wire logic        feedback_high_cmp,
  input  wire logic        feedback_low_cmp,
  input  wire logic        protect_active,
  input  wire logic        supply_lockout,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             gate_drive,
  output logic             turn_on_spike_mask,
  output logic             burst_active,
  output logic             burst_limit_gate,
  output logic             extend_charge_switch,
  output logic             extend_discharge_switch,
  output logic             feedback_discharge_switch,
  output logic      [1:0]  burst_level,
  output logic             level_valid,
  output logic             auto_restart
);
  // ****************************************************************
  // derived cycle counts
  // ****************************************************************
  localparam int LEB_N_CYC = (`SMPS_LEB_NORM_NS * `SMPS_CLK_MHZ + 999) / 1000;
  localparam int LEB_B_CYC = (`SMPS_LEB_BURST_NS * `SMPS_CLK_MHZ + 999) / 1000;
  localparam int SPIKE_CYC = `SMPS_SPIKE_US * `SMPS_CLK_MHZ;
  localparam int BLK_W = $clog2(BLANK_CYC + 1);
  localparam int DET_W = $clog2(DETECT_CYC + 1);
  localparam int SPK_W = $clog2(SPIKE_CYC + 1);
  localparam int LEB_W = $clog2(LEB_N_CYC + 1);
  localparam int EXT_W = $clog2(`SMPS_EXT_TARGET + 1);

  // ****************************************************************
  // comparator synchronisation
  // ****************************************************************
  cmp_if #(.N(`CMP_NUM)) cmp ();
  logic [`CMP_NUM-1:0] cmp_raw;

  assign cmp_raw[`CMP_PEAK]   = peak_limit_comparator;
  assign cmp_raw[`CMP_BURST]  = burst_limit_comparator;
  assign cmp_raw[`CMP_AMP]    = amp_cmp;
  assign cmp_raw[`CMP_OVER]   = overload_cmp;
  assign cmp_raw[`CMP_BENTRY] = burst_entry_cmp;
  assign cmp_raw[`CMP_BEXIT]  = burst_exit_cmp;
  assign cmp_raw[`CMP_EXTH]   = extend_high_comparator;
  assign cmp_raw[`CMP_EXTL]   = extend_low_comparator;
  assign cmp_raw[`CMP_FBH]    = feedback_high_cmp;
  assign cmp_raw[`CMP_FBL]    = feedback_low_cmp;
  assign cmp_raw[`CMP_PROT]   = protect_active;
  assign cmp_raw[`CMP_LOCK]   = supply_lockout;

  // every comparator passes the staged synchroniser
  cmp_sync #(.N(`CMP_NUM)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .raw     (cmp_raw),
    .out     (cmp.src)
  );

  logic lock_s;
  logic idle_rst;
  assign lock_s   = cmp.lvl[`CMP_LOCK];
  assign idle_rst = sys_rst | lock_s;

  // ****************************************************************
  // register state
  // ****************************************************************
  logic                  gate_ff;
  logic                  mask_ff;
  logic [LEB_W-1:0]      leb_cnt_ff;
  logic                  burst_ff;
  logic [BLK_W-1:0]      bblk_cnt_ff;
  smps_pkg::ov_state_e   ov_ff;
  logic [BLK_W-1:0]      oblk_cnt_ff;
  logic [EXT_W-1:0]      ext_cnt_ff;
  logic                  chg_ff;
  logic                  dis_ff;
  logic [SPK_W-1:0]      spk_cnt_ff;
  logic                  restart_ff;
  smps_pkg::det_state_e  det_ff;
  logic [DET_W-1:0]      det_tmr_ff;
  logic [DET_CNT_W-1:0]  det_cnt_ff;
  logic                  det_flop_ff;
  smps_pkg::burst_level_t lvl_ff;
  logic                  ext_en_ff;
  logic [31:0]           rdat_ff;
  logic                  ack_ff;

  // ****************************************************************
  // switching latch and turn-on mask
  // ****************************************************************
  logic [LEB_W-1:0] leb_len;
  logic             sense_ok;
  logic             peak_hit;
  logic             burst_hit;
  logic             amp_hit;
  logic             latch_off;

  assign leb_len   = burst_ff ? LEB_W'(LEB_B_CYC) : LEB_W'(LEB_N_CYC);
  assign sense_ok  = gate_ff & ~mask_ff;
  assign peak_hit  = sense_ok & cmp.lvl[`CMP_PEAK];
  assign burst_hit = sense_ok & cmp.lvl[`CMP_BURST] & burst_ff;
  assign amp_hit   = sense_ok & cmp.lvl[`CMP_AMP];
  assign latch_off = peak_hit | burst_hit | amp_hit | restart_ff;

  // latch set by oscillator, reset by any unmasked limit, the burst limit only in burst mode
  always_ff @(posedge clk)
  begin
    if (idle_rst)
      gate_ff <= 1'b0;
    else if (latch_off)
      gate_ff <= 1'b0;
    else if (osc_set)
      gate_ff <= 1'b1;
  end

  // mask timer restarts at each turn-on
  always_ff @(posedge clk)
  begin
    if (idle_rst)
    begin
      mask_ff    <= 1'b0;
      leb_cnt_ff <= '0;
    end
    else if (osc_set & ~gate_ff & ~latch_off)
    begin
      mask_ff    <= 1'b1;
      leb_cnt_ff <= leb_len - LEB_W'(1);
    end
    else if (mask_ff)
    begin
      mask_ff    <= (leb_cnt_ff != '0);
      leb_cnt_ff <= leb_cnt_ff - LEB_W'(1);
    end
  end

  // ****************************************************************
  // burst mode entry and exit
  // ****************************************************************
  logic burst_allowed;
  logic burst_low;
  logic bblk_done;

  assign burst_allowed = (det_ff == smps_pkg::DET_DONE) & (lvl_ff != 2'h3);
  assign burst_low     = cmp.lvl[`CMP_BENTRY] & burst_allowed;
  assign bblk_done     = (bblk_cnt_ff == BLK_W'(BLANK_CYC - 1));

  // blanking counter held at zero unless feedback stays low while burst is allowed and not yet active
  always_ff @(posedge clk)
  begin
    if (idle_rst | burst_ff | ~burst_low)
      bblk_cnt_ff <= '0;
    else if (!bblk_done)
      bblk_cnt_ff <= bblk_cnt_ff + BLK_W'(1);
  end

  // burst flag taken after blanking, cleared by exit comparator
  always_ff @(posedge clk)
  begin
    if (idle_rst)
      burst_ff <= 1'b0;
    else if (burst_ff & cmp.lvl[`CMP_BEXIT])
      burst_ff <= 1'b0;
    else if (burst_low & bblk_done)
      burst_ff <= 1'b1;
  end

  // ****************************************************************
  // overload blanking, extension and restart
  // ****************************************************************
  logic over_s;
  logic oblk_done;
  logic ext_done;
  logic release_gate;
  logic spk_done;

  assign over_s       = cmp.lvl[`CMP_OVER];
  assign oblk_done    = (oblk_cnt_ff == BLK_W'(BLANK_CYC - 1));
  assign ext_done     = (ext_cnt_ff == EXT_W'(`SMPS_EXT_TARGET));
  assign release_gate = over_s & (~ext_en_ff | ext_done);
  assign spk_done     = (spk_cnt_ff == SPK_W'(SPIKE_CYC - 1));

  // overload sequence
  always_ff @(posedge clk)
  begin
    if (idle_rst)
      ov_ff <= smps_pkg::OV_IDLE;
    else
    begin
      case (ov_ff)
        smps_pkg::OV_IDLE:
          if (over_s)
            ov_ff <= smps_pkg::OV_BASIC;
        smps_pkg::OV_BASIC:
          if (!over_s)
            ov_ff <= smps_pkg::OV_IDLE;
          else if (oblk_done)
            ov_ff <= ext_en_ff ? smps_pkg::OV_EXTEND : smps_pkg::OV_SPIKE;
        smps_pkg::OV_EXTEND:
          if (!over_s)
            ov_ff <= smps_pkg::OV_IDLE;
          else if (release_gate)
            ov_ff <= smps_pkg::OV_SPIKE;
        smps_pkg::OV_SPIKE:
          if (!release_gate)
            ov_ff <= smps_pkg::OV_IDLE;
          else if (spk_done)
            ov_ff <= smps_pkg::OV_RESTART;
        default:
          ov_ff <= over_s ? smps_pkg::OV_RESTART : smps_pkg::OV_IDLE;
      endcase
    end
  end

  // built-in blanking and spike delay counters
  always_ff @(posedge clk)
  begin
    if (idle_rst || ov_ff != smps_pkg::OV_BASIC)
      oblk_cnt_ff <= '0;
    else
      oblk_cnt_ff <= oblk_cnt_ff + BLK_W'(1);
    if (idle_rst || ov_ff != smps_pkg::OV_SPIKE)
      spk_cnt_ff <= '0;
    else
      spk_cnt_ff <= spk_cnt_ff + SPK_W'(1);
  end

  // extension capacitor cycling and cycle count
  always_ff @(posedge clk)
  begin
    if (idle_rst || ov_ff == smps_pkg::OV_IDLE)
    begin
      ext_cnt_ff <= '0;
      chg_ff     <= 1'b0;
      dis_ff     <= 1'b0;
    end
    else if (ext_done || ov_ff != smps_pkg::OV_EXTEND)
    begin
      chg_ff <= 1'b0;
      dis_ff <= 1'b0;
    end
    else if (!chg_ff && !dis_ff)
      chg_ff <= 1'b1;
    else if (chg_ff && cmp.lvl[`CMP_EXTH])
    begin
      ext_cnt_ff <= ext_cnt_ff + EXT_W'(1);
      chg_ff     <= 1'b0;
      dis_ff     <= 1'b1;
    end
    else if (dis_ff && cmp.lvl[`CMP_EXTL])
    begin
      dis_ff <= 1'b0;
      chg_ff <= 1'b1;
    end
  end

  // restart request held until cleared by software or lockout
  logic rclr_wr;
  always_ff @(posedge clk)
  begin
    if (idle_rst)
      restart_ff <= 1'b0;
    else if (ov_ff == smps_pkg::OV_SPIKE && spk_done && release_gate)
      restart_ff <= 1'b1;
    else if (rclr_wr)
      restart_ff <= 1'b0;
  end

  // ****************************************************************
  // burst level detection, first start-up only
  // ****************************************************************
  logic det_end;
  smps_pkg::burst_level_t lvl_pick;

  function automatic smps_pkg::burst_level_t pick_level(input logic [DET_CNT_W-1:0] n);
    if (n >= DET_CNT_W'(LVL3_MIN))
      pick_level = 2'h3;
    else if (n >= DET_CNT_W'(LVL2_MIN))
      pick_level = 2'h2;
    else if (n >= DET_CNT_W'(LVL1_MIN))
      pick_level = 2'h1;
    else
      pick_level = 2'h0;
  endfunction

  assign det_end  = (det_tmr_ff == DET_W'(DETECT_CYC - 1));
  assign lvl_pick = pick_level(det_cnt_ff);

  // sequence state survives lockout once done; a lockout during the run restarts detection
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      det_ff <= smps_pkg::DET_WAIT;
    else
    begin
      case (det_ff)
        smps_pkg::DET_WAIT:
          if (!lock_s && !cmp.lvl[`CMP_PROT])
            det_ff <= smps_pkg::DET_RUN;
        smps_pkg::DET_RUN:
          if (lock_s)
            det_ff <= smps_pkg::DET_WAIT;
          else if (det_end)
            det_ff <= smps_pkg::DET_DONE;
        default:
          det_ff <= smps_pkg::DET_DONE;
      endcase
    end
  end

  // charge cycle counting on the feedback capacitor
  always_ff @(posedge clk)
  begin
    if (idle_rst || det_ff != smps_pkg::DET_RUN)
    begin
      det_tmr_ff  <= '0;
      det_flop_ff <= 1'b0;
      if (det_ff == smps_pkg::DET_WAIT)
        det_cnt_ff <= '0;
    end
    else
    begin
      det_tmr_ff <= det_tmr_ff + DET_W'(1);
      if (!det_flop_ff && cmp.lvl[`CMP_FBH])
      begin
        det_flop_ff <= 1'b1;
        det_cnt_ff  <= det_cnt_ff + DET_CNT_W'(1);
      end
      else if (det_flop_ff && cmp.lvl[`CMP_FBL])
        det_flop_ff <= 1'b0;
    end
  end

  // level latched at the end of the window
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lvl_ff <= 2'h0;
    else if (det_ff == smps_pkg::DET_RUN && det_end && !lock_s)
      lvl_ff <= lvl_pick;
  end

  // ****************************************************************
  // wishbone register slave
  // ****************************************************************
  logic        req;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_ext;
  logic        hit_det;
  logic [31:0] rd_mux;
  logic        ctrl_wr;

  assign req      = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign hit_ctrl = (wb_adr_i == `REG_CTRL);
  assign hit_stat = (wb_adr_i == `REG_STATUS);
  assign hit_ext  = (wb_adr_i == `REG_EXTCNT);
  assign hit_det  = (wb_adr_i == `REG_DETCNT);
  assign ctrl_wr  = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & hit_ctrl & wb_sel_i[0];
  assign rclr_wr  = ctrl_wr & wb_dat_i[`CTRL_RCLR];
  assign rd_mux   = hit_ctrl ? {31'h0, ext_en_ff} :
                    hit_stat ? {21'h0, ov_ff, det_flop_ff, det_ff, lvl_ff,
                                restart_ff, burst_ff, gate_ff} :
                    hit_ext  ? {{(32-EXT_W){1'b0}}, ext_cnt_ff} :
                    hit_det  ? {{(32-DET_CNT_W){1'b0}}, det_cnt_ff} : 32'h0;

  // single-cycle ack, read data captured with it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ack_ff    <= 1'b0;
      rdat_ff   <= 32'h0;
      ext_en_ff <= `CTRL_RESET;
    end
    else
    begin
      ack_ff  <= req;
      rdat_ff <= (req & ~wb_we_i) ? rd_mux : 32'h0;
      if (ctrl_wr)
        ext_en_ff <= wb_dat_i[`CTRL_EXT_EN];
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_ack_o                  = ack_ff;
  assign wb_dat_o                  = rdat_ff;
  assign gate_drive                = gate_ff;
  assign turn_on_spike_mask        = mask_ff;
  assign burst_active              = burst_ff;
  assign burst_limit_gate          = burst_ff;
  assign extend_charge_switch      = chg_ff;
  assign extend_discharge_switch   = dis_ff;
  assign feedback_discharge_switch = det_flop_ff;
  assign burst_level               = lvl_ff;
  assign level_valid               = (det_ff == smps_pkg::DET_DONE);
  assign auto_restart              = restart_ff;
endmodule
`default_nettype wire

// ---- src/smps_defs.svh ----
`ifndef SMPS_DEFS_SVH
`define SMPS_DEFS_SVH

// ****************************************************************
// clock and time figures
// ****************************************************************
`define SMPS_CLK_MHZ       100
`define SMPS_LEB_NORM_NS   220
`define SMPS_LEB_BURST_NS  180
`define SMPS_BLANK_MS      20
`define SMPS_DETECT_MS     1
`define SMPS_SPIKE_US      30
`define SMPS_EXT_TARGET    256

// ****************************************************************
// comparator bank bit positions
// ****************************************************************
`define CMP_PEAK    0
`define CMP_BURST   1
`define CMP_AMP     2
`define CMP_OVER    3
`define CMP_BENTRY  4
`define CMP_BEXIT   5
`define CMP_EXTH    6
`define CMP_EXTL    7
`define CMP_FBH     8
`define CMP_FBL     9
`define CMP_PROT    10
`define CMP_LOCK    11
`define CMP_NUM     12

// ****************************************************************
// register map and fields
// ****************************************************************
`define REG_CTRL    8'h00
`define REG_STATUS  8'h04
`define REG_EXTCNT  8'h08
`define REG_DETCNT  8'h0C
`define CTRL_EXT_EN 0
`define CTRL_RCLR   1
`define CTRL_RESET  1'h1

`endif

// ---- src/smps_pkg.sv ----
`default_nettype none
package smps_pkg;
  // overload protection sequence
  typedef enum logic [2:0] {OV_IDLE, OV_BASIC, OV_EXTEND, OV_SPIKE, OV_RESTART} ov_state_e;
  // burst level detection sequence
  typedef enum logic [1:0] {DET_WAIT, DET_RUN, DET_DONE} det_state_e;
  typedef logic [1:0] burst_level_t;
endpackage
`default_nettype wire

// ---- src/cmp_if.sv ----
`default_nettype none
interface cmp_if #(parameter int N = 12);
  logic [N-1:0] lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface
`default_nettype wire

// ---- src/cmp_sync.sv ----
`include "smps_defs.svh"
`default_nettype none
module cmp_sync #(
  parameter int N = `CMP_NUM
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [N-1:0] raw,
  cmp_if.src                out
);
  logic [N-1:0] s1_ff;
  logic [N-1:0] s2_ff;
  logic [N-1:0] s3_ff;
  logic [N-1:0] lvl_ff;
  logic [N-1:0] agree;

  // a change counts once the second and third stage agree
  assign agree = ~(s2_ff ^ s3_ff);
  assign out.lvl = lvl_ff;

  // three stage capture of the pin levels
  always_ff @(posedge clk)
  begin
    s1_ff <= raw;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
    if (sys_rst)
      lvl_ff <= s3_ff;
    else
      lvl_ff <= (agree & s3_ff) | (~agree & lvl_ff);
  end
endmodule
`default_nettype wire

// ---- verif/smps_protect_monitor.sv ----
`include "smps_defs.svh"
`default_nettype none
module smps_protect_monitor #(
  parameter int BLANK_CYC = 200
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       peak_limit_comparator,
  input wire logic       overload_cmp,
  input wire logic       burst_entry_cmp,
  input wire logic       burst_exit_cmp,
  input wire logic       supply_lockout,
  input wire logic       gate_drive,
  input wire logic       turn_on_spike_mask,
  input wire logic       burst_active,
  input wire logic       burst_limit_gate,
  input wire logic       extend_charge_switch,
  input wire logic       extend_discharge_switch,
  input wire logic       feedback_discharge_switch,
  input wire logic [1:0] burst_level,
  input wire logic       level_valid,
  input wire logic       auto_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SPIKE_CYC = `SMPS_SPIKE_US * `SMPS_CLK_MHZ;
  int   mask_len_ff;
  int   entry_run_ff;
  int   ov_run_ff;
  int   quiet_ff;
  logic mask_burst_ff;

  // run lengths of mask and inputs, cycles since lockout
  always_ff @(posedge clk)
  begin
    mask_len_ff   <= (sys_rst || !turn_on_spike_mask) ? 0 : mask_len_ff + 1;
    entry_run_ff  <= (sys_rst || !burst_entry_cmp) ? 0 : entry_run_ff + 1;
    ov_run_ff     <= (sys_rst || !overload_cmp) ? 0 : ov_run_ff + 1;
    quiet_ff      <= (sys_rst || supply_lockout) ? 0 : quiet_ff + 1;
    mask_burst_ff <= turn_on_spike_mask ? mask_burst_ff : burst_active;
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence peak_held;
    peak_limit_comparator [*5];
  endsequence
  sequence exit_held;
    burst_exit_cmp [*5];
  endsequence

  a_mask_length: assert property ($fell(turn_on_spike_mask) && quiet_ff > 30 |->
    mask_len_ff == (mask_burst_ff ? 18 : 22)) else $error("mask length wrong");
  a_mask_on_set: assert property ($rose(gate_drive) |-> $rose(turn_on_spike_mask))
    else $error("mask not started with pulse");
  a_peak_ends_pulse: assert property (peak_held ##0 (gate_drive && !turn_on_spike_mask)
    |-> ##[1:2] !gate_drive) else $error("peak hit did not end pulse");
  a_limit_gate_flag: assert property (burst_limit_gate == burst_active)
    else $error("burst limit gate differs from burst flag");
  a_no_burst_top: assert property (burst_active |-> level_valid && burst_level != 2'h3)
    else $error("burst taken without usable level");
  a_entry_persist: assert property ($rose(burst_active) |-> entry_run_ff >= BLANK_CYC)
    else $error("burst entered too early");
  a_exit_leaves: assert property (exit_held |-> ##[0:2] !burst_active)
    else $error("burst not left on exit level");
  a_switch_excl: assert property (!(extend_charge_switch && extend_discharge_switch))
    else $error("charge and discharge both closed");
  a_restart_late: assert property ($rose(auto_restart) |->
    ov_run_ff >= BLANK_CYC + SPIKE_CYC) else $error("restart before blanking and delay");
  a_ext_idle: assert property (auto_restart |-> !extend_charge_switch && !extend_discharge_switch)
    else $error("extend switches active after count end");
  a_detect_once: assert property (level_valid |=> level_valid)
    else $error("level detection restarted");
  a_fb_sw_window: assert property ($rose(feedback_discharge_switch) |-> !level_valid)
    else $error("feedback discharge outside detection");
endmodule

bind smps_protect smps_protect_monitor #(.BLANK_CYC(BLANK_CYC)) u_mon (
  .clk, .sys_rst, .peak_limit_comparator, .overload_cmp, .burst_entry_cmp, .burst_exit_cmp,
  .supply_lockout, .gate_drive, .turn_on_spike_mask, .burst_active, .burst_limit_gate,
  .extend_charge_switch, .extend_discharge_switch, .feedback_discharge_switch, .burst_level,
  .level_valid, .auto_restart
);
`default_nettype wire

// ---- verif/smps_far_side.sv ----
`default_nettype none
module smps_far_side #(
  parameter int EXT_SPAN = 3
) (
  input  wire logic       clk,
  input  wire logic       extend_charge_switch,
  input  wire logic       extend_discharge_switch,
  input  wire logic       feedback_discharge_switch,
  input  wire logic [7:0] fb_span,
  output logic            extend_high_comparator,
  output logic            extend_low_comparator,
  output logic            feedback_high_cmp,
  output logic            feedback_low_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  int ext_lvl = 0;
  int fb_lvl = 0;

  // capacitor levels: charge ramps, feedback discharge is near instant
  always @(posedge clk)
  begin
    if (extend_charge_switch && ext_lvl < EXT_SPAN) ext_lvl <= ext_lvl + 1;
    else if (extend_discharge_switch && ext_lvl > 0) ext_lvl <= ext_lvl - 1;
    if (feedback_discharge_switch) fb_lvl <= 0;
    else if (fb_lvl < int'(fb_span)) fb_lvl <= fb_lvl + 1;
  end

  // comparator outputs from the modelled pin levels
  assign extend_high_comparator = (ext_lvl >= EXT_SPAN);
  assign extend_low_comparator  = (ext_lvl == 0);
  assign feedback_high_cmp      = (fb_lvl >= int'(fb_span));
  assign feedback_low_cmp       = (fb_lvl == 0);
endmodule
`default_nettype wire

// ---- verif/smps_protection_blanking_control_bench.sv ----
`default_nettype none
module smps_protection_blanking_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BLANK = 200;
  logic        clk, sys_rst, osc_set, peak_limit_comparator, burst_limit_comparator, amp_cmp;
  logic        overload_cmp, burst_entry_cmp, burst_exit_cmp, protect_active, supply_lockout;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, gate_drive, turn_on_spike_mask;
  logic        burst_active, burst_limit_gate, extend_charge_switch, extend_discharge_switch;
  logic        feedback_discharge_switch, extend_high_comparator, extend_low_comparator;
  logic        feedback_high_cmp, feedback_low_cmp, level_valid, auto_restart, seen;
  logic        fb_high_d = 1'h0;
  logic [1:0]  burst_level;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i, fb_span;
  logic [31:0] wb_dat_i, wb_dat_o, rd, dcnt;
  logic [7:0]  spans [4] = '{8'h01, 8'h60, 8'h06, 8'h0C};
  int          n_mismatch = 0, check_count = 0, fb_rises = 0, lvl;

  smps_protect #(.BLANK_CYC(BLANK), .DETECT_CYC(100), .LVL1_MIN(2), .LVL2_MIN(4),
    .LVL3_MIN(7)) dut (.clk, .sys_rst, .osc_set, .peak_limit_comparator,
    .burst_limit_comparator, .amp_cmp, .overload_cmp, .burst_entry_cmp, .burst_exit_cmp,
    .extend_high_comparator, .extend_low_comparator, .feedback_high_cmp, .feedback_low_cmp,
    .protect_active, .supply_lockout, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .gate_drive, .turn_on_spike_mask, .burst_active,
    .burst_limit_gate, .extend_charge_switch, .extend_discharge_switch,
    .feedback_discharge_switch, .burst_level, .level_valid, .auto_restart);

  smps_far_side u_far (.clk, .extend_charge_switch, .extend_discharge_switch,
    .feedback_discharge_switch, .fb_span, .extend_high_comparator, .extend_low_comparator,
    .feedback_high_cmp, .feedback_low_cmp);

  // ****************************************************************
  // clock, feedback cycle count, watchdog
  // ****************************************************************
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // count upper feedback crossings while detection is open
  always @(posedge clk)
  begin
    fb_high_d <= feedback_high_cmp;
    if (sys_rst) fb_rises <= 0;
    else if (!level_valid && feedback_high_cmp && !fb_high_d) fb_rises <= fb_rises + 1;
  end

  // cut a hang short
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    chk(wb_ack_o, 32'h1);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
  endtask

  // start a pulse with a sense hit, check masking and shutdown
  task automatic sense_pulse(input logic [2:0] hit, input int t_hold, input logic ends);
    @(posedge clk);
    osc_set <= 1'h1;
    {amp_cmp, burst_limit_comparator, peak_limit_comparator} <= hit;
    @(posedge clk);
    osc_set <= 1'h0;
    ticks(t_hold - 1);
    chk(gate_drive, 32'h1);
    ticks(12);
    chk(gate_drive, {31'h0, !ends});
    {amp_cmp, burst_limit_comparator, peak_limit_comparator} <= 3'h1;
    ticks(12);
    chk(gate_drive, 32'h0);
    {amp_cmp, burst_limit_comparator, peak_limit_comparator} <= 3'h0;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    {sys_rst, osc_set, peak_limit_comparator, burst_limit_comparator, amp_cmp} = 5'h10;
    {overload_cmp, burst_entry_cmp, burst_exit_cmp, protect_active, supply_lockout} = 5'h00;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_sel_i = 4'hF;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    fb_span  = 8'h01;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      sys_rst <= 1'h1;
      fb_span <= spans[i];
      protect_active <= (i == 0);
      ticks(20);
      sys_rst <= 1'h0;
      if (i == 0)
      begin
        ticks(150);
        chk(level_valid, 32'h0);
        protect_active <= 1'h0;
      end
      for (int k = 0; k < 1000 && level_valid !== 1'b1; k++) @(posedge clk);
      chk(level_valid, 32'h1);
      wb(1'h0, 8'h0C, 32'h0);
      dcnt = rd;
      chk({31'h0, dcnt + 1 >= fb_rises && fb_rises + 1 >= dcnt}, 32'h1);
      lvl = dcnt < 2 ? 0 : dcnt < 4 ? 1 : dcnt < 7 ? 2 : 3;
      chk(burst_level, lvl);
      burst_entry_cmp <= 1'h1;
      ticks(BLANK - 10);
      chk(burst_active, 32'h0);
      ticks(30);
      chk(burst_active, {31'h0, lvl != 3});
      if (lvl != 3) sense_pulse(3'h2, 18, 1'h1);
      burst_exit_cmp <= 1'h1;
      burst_entry_cmp <= 1'h0;
      ticks(10);
      chk(burst_active, 32'h0);
      burst_exit_cmp <= 1'h0;
      $display("level test %0d done", i);
    end
    sense_pulse(3'h1, 22, 1'h1);
    sense_pulse(3'h4, 22, 1'h1);
    sense_pulse(3'h2, 22, 1'h0);
    wb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    wb(1'h0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    $display("pulse and register tests done");
    overload_cmp <= 1'h1;
    ticks(BLANK - 10);
    chk(extend_charge_switch, 32'h0);
    for (int k = 0; k < 12000 && auto_restart !== 1'b1; k++) @(posedge clk);
    chk(auto_restart, 32'h1);
    wb(1'h0, 8'h08, 32'h0);
    chk(rd, 32'h0000_0100);
    wb(1'h1, 8'h00, 32'h3);
    ticks(3);
    chk(auto_restart, 32'h0);
    overload_cmp <= 1'h0;
    ticks(10);
    wb(1'h1, 8'h00, 32'h0);
    overload_cmp <= 1'h1;
    seen = 1'h0;
    for (int k = 0; k < 4000 && auto_restart !== 1'b1; k++)
    begin
      @(posedge clk);
      seen = seen | extend_charge_switch;
    end
    chk(auto_restart, 32'h1);
    chk(seen, 32'h0);
    supply_lockout <= 1'h1;
    ticks(10);
    chk(auto_restart, 32'h0);
    chk(gate_drive, 32'h0);
    overload_cmp <= 1'h0;
    supply_lockout <= 1'h0;
    ticks(200);
    chk(level_valid, 32'h1);
    wb(1'h0, 8'h0C, 32'h0);
    chk(rd, dcnt);
    $display("overload tests done");
    summarize();
  end
endmodule
`default_nettype wire
